/* File: design/rtt_pkg.sv */
// rtt_pkg: register map, field positions and timing counts of the reader timer pair
// assumes: byte registers on a 32-bit avalon-mm slave, one word per register
package rtt_pkg;
    // --------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------------
    localparam logic [7:0] RUN_CTRL_IDX = 8'h0e;
    localparam logic [7:0] U0_RELOAD_HIGH_IDX = 8'h10;
    localparam logic [7:0] U0_RELOAD_LOW_IDX = 8'h11;
    localparam logic [7:0] U0_COUNT_HIGH_IDX = 8'h12;
    localparam logic [7:0] U0_COUNT_LOW_IDX = 8'h13;
    localparam logic [7:0] U1_CONTROL_IDX = 8'h14;
    localparam logic [7:0] U1_RELOAD_HIGH_IDX = 8'h15;
    localparam logic [7:0] U1_RELOAD_LOW_IDX = 8'h16;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
    localparam logic [7:0] U0_CONTROL_IDX = 8'h22;
    // --------------------------------------------------------------------
    // control field positions
    // --------------------------------------------------------------------
    localparam int STOP_RX_BIT = 7;
    localparam int START_SEL_LSB = 4;
    localparam int RESTART_BIT = 3;
    localparam int TICK_SEL_LSB = 0;
    localparam int RUN_FLAG_LSB = 4;
    localparam int RUN_MASK_LSB = 0;
    localparam int IRQ_U0_BIT = 0;
    localparam int IRQ_U1_BIT = 1;
    // --------------------------------------------------------------------
    // field encodings and reset values
    // --------------------------------------------------------------------
    localparam logic [1:0] START_NONE = 2'h0;
    localparam logic [1:0] START_TX_END = 2'h1;
    localparam logic [1:0] START_LFO_PLAIN = 2'h2;
    localparam logic [1:0] START_LFO_UFL = 2'h3;
    localparam logic [1:0] TICK_SYS = 2'h0;
    localparam logic [1:0] TICK_SLOW = 2'h1;
    localparam logic [1:0] TICK_UNIT0 = 2'h2;
    localparam logic [1:0] TICK_UNIT2 = 2'h3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RW_MASK = 8'hbb;
    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int CLK_HZ = 100000000;
    localparam int SLOW_TICK_HZ = 211875;
    // integer divide: the slow tick runs slightly fast; clamp guards a slow system clock
    localparam int SLOW_TICK_DIV_RAW = CLK_HZ / SLOW_TICK_HZ;
    localparam int SLOW_TICK_DIV = (SLOW_TICK_DIV_RAW < 1) ? 1 : SLOW_TICK_DIV_RAW;
endpackage : rtt_pkg

/* File: design/rtt_timer_pair.sv */
// rtt_timer_pair: two 16-bit down-counters with reload, run control and interrupts
// assumes: one clock; frame events arrive as synchronous one-cycle pulses
`timescale 1ns/1ps
module rtt_timer_pair #(
    parameter int COUNT_W = 16,
    parameter int SLOW_DIV = rtt_pkg::SLOW_TICK_DIV
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic tx_end_i,
    input wire logic rx_nibble_i,
    input wire logic lfo_i,
    input wire logic unit2_underflow_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    output logic irq_o,
    output logic unit0_underflow_o,
    output logic unit1_underflow_o
);
    // --------------------------------------------------------------------
    // state
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {RTT_IDLE, RTT_ACK} rtt_bus_e;

    typedef struct packed {
        rtt_bus_e bus;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [7:0] u0_reload_high;
        logic [7:0] u0_reload_low;
        logic [7:0] u0_control;
        logic [7:0] u1_control;
        logic [7:0] u1_reload_high;
        logic [7:0] u1_reload_low;
        logic [COUNT_W-1:0] u0_count;
        logic [COUNT_W-1:0] u1_count;
        logic [1:0] running;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
        logic [1:0] ufl;
        logic [15:0] slow_cnt;
        logic slow_tick;
        logic lfo_last;
    } rtt_state_s;

    rtt_state_s st_reg;
    rtt_state_s st_next;
    logic [1:0] rst_sync_reg;
    logic rst_int_b;

    // --------------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_reg[1];

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic tick_of(input logic [1:0] sel, input logic slow,
                                     input logic u0_ufl, input logic u2_ufl);
        logic t;
        t = 1'b0;
        case (sel)
            rtt_pkg::TICK_SYS: t = 1'b1;
            rtt_pkg::TICK_SLOW: t = slow;
            rtt_pkg::TICK_UNIT0: t = u0_ufl;
            default: t = u2_ufl;
        endcase
        return t;
    endfunction : tick_of

    function automatic logic is_trim(input logic [1:0] start_sel);
        return start_sel[1];
    endfunction : is_trim

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic wr_hit;
    logic [7:0] ctl [2];
    logic [COUNT_W-1:0] reload [2];
    logic [COUNT_W-1:0] cnt [2];
    logic [1:0] start_ev;
    logic [1:0] stop_ev;
    logic [1:0] tick;
    logic [1:0] ufl_now;
    logic lfo_rise;

    always_comb begin
        st_next = st_reg;
        idx = avs_address_i[9:2];
        wbyte = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
        wr_hit = avs_write_i && avs_byteenable_i[0] && st_reg.bus == RTT_IDLE;
        ctl[0] = st_reg.u0_control;
        ctl[1] = st_reg.u1_control;
        reload[0] = COUNT_W'({st_reg.u0_reload_high, st_reg.u0_reload_low});
        reload[1] = COUNT_W'({st_reg.u1_reload_high, st_reg.u1_reload_low});
        cnt[0] = st_reg.u0_count;
        cnt[1] = st_reg.u1_count;
        lfo_rise = lfo_i && !st_reg.lfo_last;
        st_next.lfo_last = lfo_i;
        start_ev = 2'h0;
        stop_ev = 2'h0;
        tick = 2'h0;
        ufl_now = 2'h0;

        // slow tick prescaler
        if (st_reg.slow_cnt >= 16'(SLOW_DIV - 1)) begin
            st_next.slow_cnt = 16'h0000;
            st_next.slow_tick = 1'b1;
        end else begin
            st_next.slow_cnt = st_reg.slow_cnt + 16'h0001;
            st_next.slow_tick = 1'b0;
        end

        // hardware start and stop events per unit
        for (int u = 0; u < 2; u++) begin
            case (ctl[u][rtt_pkg::START_SEL_LSB +: 2])
                rtt_pkg::START_TX_END: start_ev[u] = tx_end_i;
                rtt_pkg::START_LFO_PLAIN,
                rtt_pkg::START_LFO_UFL: begin
                    // trimming: a rising edge starts an idle timer, stops a running one
                    start_ev[u] = lfo_rise && !st_reg.running[u];
                    stop_ev[u] = lfo_rise && st_reg.running[u];
                end
                default: ;
            endcase
            if (ctl[u][rtt_pkg::STOP_RX_BIT] && !is_trim(ctl[u][rtt_pkg::START_SEL_LSB +: 2])
                && rx_nibble_i) begin
                stop_ev[u] = 1'b1;
            end
        end

        // global run-control write
        st_next.running = st_reg.running;
        if (wr_hit && idx == rtt_pkg::RUN_CTRL_IDX) begin
            for (int u = 0; u < 2; u++) begin
                if (wbyte[rtt_pkg::RUN_MASK_LSB + u]) begin
                    if (wbyte[rtt_pkg::RUN_FLAG_LSB + u]) begin
                        start_ev[u] = 1'b1;
                    end else begin
                        stop_ev[u] = 1'b1;
                    end
                end
            end
        end

        // count
        // unit0: select 10 counts third-timer underflows, 11 counts unit1 underflows
        tick[0] = tick_of(ctl[0][rtt_pkg::TICK_SEL_LSB +: 2], st_reg.slow_tick, unit2_underflow_i,
                          st_reg.ufl[1]);
        tick[1] = tick_of(ctl[1][rtt_pkg::TICK_SEL_LSB +: 2], st_reg.slow_tick, st_reg.ufl[0],
                          unit2_underflow_i);
        for (int u = 0; u < 2; u++) begin
            if (start_ev[u]) begin
                cnt[u] = reload[u];
                st_next.running[u] = 1'b1;
            end else if (stop_ev[u]) begin
                st_next.running[u] = 1'b0;
            end else if (st_reg.running[u] && tick[u]) begin
                if (cnt[u] == '0) begin
                    // plain trimming mode reports no underflow
                    ufl_now[u] = ctl[u][rtt_pkg::START_SEL_LSB +: 2] != rtt_pkg::START_LFO_PLAIN;
                    if (ctl[u][rtt_pkg::RESTART_BIT]) begin
                        cnt[u] = reload[u];
                    end else begin
                        st_next.running[u] = 1'b0;
                    end
                end else begin
                    cnt[u] = cnt[u] - COUNT_W'(1);
                end
            end
        end
        st_next.u0_count = cnt[0];
        st_next.u1_count = cnt[1];
        st_next.ufl = ufl_now;

        // register writes, sticky flags set beats clear
        if (wr_hit) begin
            if (idx == rtt_pkg::U0_RELOAD_HIGH_IDX) begin
                st_next.u0_reload_high = wbyte;
            end else if (idx == rtt_pkg::U0_RELOAD_LOW_IDX) begin
                st_next.u0_reload_low = wbyte;
            end else if (idx == rtt_pkg::U1_CONTROL_IDX) begin
                st_next.u1_control = wbyte & rtt_pkg::CONTROL_RW_MASK;
            end else if (idx == rtt_pkg::U0_CONTROL_IDX) begin
                st_next.u0_control = wbyte & rtt_pkg::CONTROL_RW_MASK;
            end else if (idx == rtt_pkg::U1_RELOAD_HIGH_IDX) begin
                st_next.u1_reload_high = wbyte;
            end else if (idx == rtt_pkg::U1_RELOAD_LOW_IDX) begin
                st_next.u1_reload_low = wbyte;
            end else if (idx == rtt_pkg::IRQ_STATUS_IDX) begin
                st_next.irq_status = st_reg.irq_status & ~wbyte[1:0];
            end else if (idx == rtt_pkg::IRQ_MASK_IDX) begin
                st_next.irq_mask = wbyte[1:0];
            end
        end
        st_next.irq_status = st_next.irq_status | ufl_now;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // bus answer: one wait cycle, then ack
        st_next.resp = 2'h0;
        if (st_reg.bus == RTT_ACK) begin
            st_next.bus = RTT_IDLE;
        end else if (avs_read_i || avs_write_i) begin
            st_next.bus = RTT_ACK;
            st_next.rdata = 32'h0;
            if (idx == rtt_pkg::RUN_CTRL_IDX) begin
                st_next.rdata[7:0] = {2'h0, st_next.running, 4'h0};
            end else if (idx == rtt_pkg::U0_RELOAD_HIGH_IDX) begin
                st_next.rdata[7:0] = st_reg.u0_reload_high;
            end else if (idx == rtt_pkg::U0_RELOAD_LOW_IDX) begin
                st_next.rdata[7:0] = st_reg.u0_reload_low;
            end else if (idx == rtt_pkg::U0_COUNT_HIGH_IDX) begin
                st_next.rdata[7:0] = st_reg.u0_count[15:8];
            end else if (idx == rtt_pkg::U0_COUNT_LOW_IDX) begin
                st_next.rdata[7:0] = st_reg.u0_count[7:0];
            end else if (idx == rtt_pkg::U1_CONTROL_IDX) begin
                st_next.rdata[7:0] = st_reg.u1_control;
            end else if (idx == rtt_pkg::U1_RELOAD_HIGH_IDX) begin
                st_next.rdata[7:0] = st_reg.u1_reload_high;
            end else if (idx == rtt_pkg::U1_RELOAD_LOW_IDX) begin
                st_next.rdata[7:0] = st_reg.u1_reload_low;
            end else if (idx == rtt_pkg::IRQ_STATUS_IDX) begin
                st_next.rdata[7:0] = {6'h0, st_reg.irq_status};
            end else if (idx == rtt_pkg::IRQ_MASK_IDX) begin
                st_next.rdata[7:0] = {6'h0, st_reg.irq_mask};
            end else if (idx == rtt_pkg::U0_CONTROL_IDX) begin
                st_next.rdata[7:0] = st_reg.u0_control;
            end else begin
                st_next.resp = 2'h2;
            end
        end
    end

    // --------------------------------------------------------------------
    // registers
    // --------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_int_b) begin
        if (!rst_int_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_o = st_reg.rdata;
    assign avs_waitrequest_o = !(st_reg.bus == RTT_ACK);
    assign avs_response_o = st_reg.resp;
    assign irq_o = st_reg.irq;
    assign unit0_underflow_o = st_reg.ufl[0];
    assign unit1_underflow_o = st_reg.ufl[1];
endmodule : rtt_timer_pair

/* File: bench/rtt_timer_pair_asserts.sv */
// rtt_timer_pair_asserts: port-level checks of the timer pair
// assumes: bound to rtt_timer_pair, one clock, active-low reset
`timescale 1ns/1ps
module rtt_timer_pair_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    input wire logic irq_o,
    input wire logic unit1_underflow_o
);
    // ------------------------------------------------------------
    // mask shadow, rebuilt from bus writes
    // ------------------------------------------------------------
    logic [7:0] mask_reg;
    logic [7:0] idx;
    logic req;
    logic mapped;
    assign idx = avs_address_i[9:2];
    assign req = avs_read_i || avs_write_i;
    assign mapped = idx inside {8'h0e, [8'h10:8'h16], 8'h20, 8'h21, 8'h22};
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_reg <= 8'h00;
        end else if (avs_write_i && avs_waitrequest_o && avs_byteenable_i[0] && idx == 8'h21) begin
            mask_reg <= avs_writedata_i[7:0];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    ack_after_req_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no answer one cycle after a request");
    ack_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held longer than one cycle");
    ack_cause_a: assert property (!avs_waitrequest_o |-> $past(req))
        else $error("answer without a request");
    unmapped_read_a: assert property (avs_read_i && avs_waitrequest_o && !mapped
        |=> avs_response_o == 2'b10 && avs_readdata_o == 32'h0) else $error("unmapped read not refused");
    mapped_read_a: assert property (avs_read_i && avs_waitrequest_o && mapped |=> avs_response_o == 2'b00)
        else $error("mapped read refused");
    upper_zero_a: assert property (!avs_waitrequest_o && $past(avs_read_i) |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    irq_raise_a: assert property (unit1_underflow_o && mask_reg[1] |-> ##[1:2] irq_o)
        else $error("unmasked underflow raised no interrupt");
    irq_quiet_a: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00
        && $past(mask_reg, 2) == 8'h00 |-> !irq_o) else $error("interrupt with all sources masked");
endmodule : rtt_timer_pair_asserts

bind rtt_timer_pair rtt_timer_pair_asserts u_asserts (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .irq_o(irq_o),
    .unit1_underflow_o(unit1_underflow_o));

/* File: bench/rtt_timer_pair_tb.sv */
// rtt_timer_pair_tb: self-checking bench for the timer pair over avalon-mm
// assumes: checker bound separately; third-timer underflows come from this bench
`timescale 1ns/1ps
module rtt_timer_pair_tb;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic [3:0] ev = 4'h0; // third-timer underflow, tx end, rx nibble, slow oscillator
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] avs_response_o;
    logic irq_o;
    logic u0_ufl;
    logic u1_ufl;
    logic [33:0] exp_q[$];
    logic [15:0] r0, r1, r2, v;
    int errors = 0;
    int comparisons = 0;
    int ufl_seen = 0;
    int n, k;
    rtt_timer_pair dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .tx_end_i(ev[1]), .rx_nibble_i(ev[2]),
        .lfo_i(ev[3]), .unit2_underflow_i(ev[0]), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .irq_o(irq_o),
        .unit0_underflow_o(u0_ufl), .unit1_underflow_o(u1_ufl));
    always #5 ref_clk_i = ~ref_clk_i;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] lanes);
        int c;
        @(posedge ref_clk_i);
        addr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        be <= lanes;
        c = 0;
        do begin
            @(posedge ref_clk_i);
            c++;
        end while (avs_waitrequest_o !== 1'b0 && c < 20);
        if (c >= 20) errors++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask : wreg
    task automatic rreg(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
        exp_q.push_back({resp, 24'h0, d});
        bus(1'b0, idx, 8'h00, 4'hf);
    endtask : rreg
    task automatic rcnt(input logic [15:0] c);
        rreg(8'h12, c[15:8], 2'b00);
        rreg(8'h13, c[7:0], 2'b00);
    endtask : rcnt
    // one-cycle event with a gap, so chained ticks settle before the next
    task automatic pulse(input int which, input int cnt);
        repeat (cnt) begin
            @(posedge ref_clk_i);
            ev[which] <= 1'b1;
            @(posedge ref_clk_i);
            ev <= 4'h0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask : pulse
    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // monitor: read answers against the oldest note, underflow count
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rd && avs_waitrequest_o === 1'b0) check({avs_response_o, avs_readdata_o}, exp_q.pop_front());
        if (u1_ufl === 1'b1) ufl_seen++;
    end
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hbd7c));
        r0 = 16'(32 + $urandom % 32'hff00);
        r1 = 16'h0100 | 16'($urandom);
        r2 = 16'h0100 | 16'($urandom);
        n = 1 + $urandom % 12;
        repeat (8) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rreg(8'h10, 8'h00, 2'b00);
        wreg(8'h14, 8'hff);
        rreg(8'h14, 8'hbb, 2'b00);
        bus(1'b1, 8'h10, 8'h5a, 4'he);
        rreg(8'h10, 8'h00, 2'b00);
        wreg(8'h12, 8'hff);
        rcnt(16'h0000);
        rreg(8'h30, 8'h00, 2'b10);
        // unit1 ticks on external pulses, unit0 on unit1 underflows: exact counts
        wreg(8'h15, 8'h00);
        wreg(8'h16, 8'h00);
        wreg(8'h14, 8'h0b);
        wreg(8'h10, r0[15:8]);
        wreg(8'h11, r0[7:0]);
        wreg(8'h22, 8'h03);
        wreg(8'h21, 8'h02);
        wreg(8'h0e, 8'h33);
        pulse(0, n);
        wreg(8'h10, r1[15:8]);
        wreg(8'h11, r1[7:0]);
        pulse(0, 1);
        v = r0 - 16'(n) - 16'h1;
        rcnt(v);
        check(34'(ufl_seen), 34'(n + 1));
        check(34'(irq_o), 34'h1);
        rreg(8'h20, 8'h02, 2'b00);
        wreg(8'h0e, 8'hf0);
        pulse(0, 1);
        wreg(8'h0e, 8'h01);
        pulse(0, 2);
        rcnt(v - 16'h1);
        wreg(8'h0e, 8'h11);
        rcnt(r1);
        wreg(8'h20, 8'h02);
        rreg(8'h20, 8'h00, 2'b00);
        check(34'(irq_o), 34'h0);
        // start and stop selection: none, transmit end, receive stop, oscillator trimming
        wreg(8'h0e, 8'h01);
        wreg(8'h10, r2[15:8]);
        wreg(8'h11, r2[7:0]);
        wreg(8'h22, 8'h03);
        pulse(1, 1);
        rcnt(r1);
        wreg(8'h22, 8'h13);
        pulse(1, 1);
        pulse(0, 1);
        rcnt(r2 - 16'h1);
        wreg(8'h22, 8'h93);
        pulse(2, 1);
        pulse(0, 1);
        rcnt(r2 - 16'h1);
        for (int m = 2; m < 4; m++) begin
            wreg(8'h22, 8'h83 | 8'(m << 4));
            pulse(3, 1);
            pulse(2, 1);
            pulse(0, 1);
            pulse(3, 1);
            pulse(0, 1);
            rcnt(r2 - 16'h1);
        end
        // unit1 on system and slow tick, halting at zero, masked then unmasked
        wreg(8'h0e, 8'h02);
        wreg(8'h16, 8'h10);
        for (int s = 0; s < 2; s++) begin
            wreg(8'h20, 8'h03);
            wreg(8'h21, 8'(s << 1));
            wreg(8'h14, 8'(s));
            k = ufl_seen;
            wreg(8'h0e, 8'h22);
            repeat (10) @(posedge ref_clk_i);
            check(34'(ufl_seen - k), 34'h0);
            repeat (60 + s * 17 * rtt_pkg::SLOW_TICK_DIV) @(posedge ref_clk_i);
            check(34'(ufl_seen - k), 34'h1);
            check(34'(irq_o), 34'(s));
        end
        end_of_test();
    end
endmodule : rtt_timer_pair_tb
